//--- dbe_top.sv
// Purpose: Data-space paging registers and nonvolatile page controller.
// Assumes: Classic Wishbone slave; data-space index n at byte address 4n.
// Notes: Every access is acknowledged two edges after it is presented.
`timescale 1ns/1ps
`default_nettype none
`include "dbe_defines.svh"

module dbe_top #(
  parameter int PROG_CYCLES = `DBE_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [11:0] prog_addr_o,
  input wire logic [7:0] prog_data_i,
  input wire logic stop_i,
  output logic nv_powered_o,
  output logic nv_busy_o
);
  import dbe_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    dbe_step_t step;
    logic ack;
    logic [7:0] rdata;
    logic [7:0] idx;
    logic wr;
    logic [7:0] wdata;
    logic [11:0] prog_addr;
    logic [7:0] win_page;
    logic [7:0] bank_sel;
    logic nv_standby;
    logic nv_write_enable;
    logic row_mode_enable;
    logic row_program_start;
    logic nv_busy_flag;
    logic row_cycle;
    logic [`DBE_CNT_W-1:0] cnt;
    logic [5:0] pend_addr;
    logic [7:0] pend_data;
    logic powered;
    logic [63:0][7:0] nv_mem;
    logic [63:0][7:0] ram2;
  } dbe_state_t;

  localparam logic [`DBE_CNT_W-1:0] PROG_LAST =
    `DBE_CNT_W'(PROG_CYCLES - 1);

  dbe_state_t s_q;
  dbe_state_t s_d;
  dbe_row_req_t row_req;
  dbe_row_view_t row_view;

  // ==========================================================
  // Row latches
  dbe_row_latch u_row (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(row_req),
    .view_o(row_view)
  );

  // ==========================================================
  // Decode helpers
  logic sel_paged;
  logic sel_win;
  logic bank_nv;
  logic bank_ram;
  logic nv_live;
  logic [5:0] off;
  logic [2:0] ctl_rd;
  logic start_row;
  logic [7:0] wd;
  logic done;

  assign off = s_q.idx[5:0];
  assign sel_paged = s_q.idx <= `DBE_PAGED_TOP;
  assign sel_win = s_q.idx >= `DBE_WIN_BASE && s_q.idx <= `DBE_WIN_TOP;
  // Several bank bits at once match neither value and map nothing
  assign bank_nv = s_q.bank_sel == `DBE_BANK_NV0;
  assign bank_ram = s_q.bank_sel == `DBE_BANK_RAM2;
  // Standby, STOP or a running cycle void every nonvolatile access
  assign nv_live = bank_nv && !s_q.nv_standby && !stop_i
    && !s_q.nv_busy_flag;
  assign wd = s_q.wdata;
  assign ctl_rd = 3'b000;
  assign done = s_q.nv_busy_flag && s_q.cnt == '0;

  // Row start needs write enable and row mode in the same write, row mode already armed
  assign start_row = wd[`DBE_CTL_ROW_START] && wd[`DBE_CTL_WR_EN]
    && wd[`DBE_CTL_ROW_MODE] && s_q.row_mode_enable;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    row_req = '0;
    s_d.powered = !s_q.nv_standby && !stop_i;

    // ----- Programming cycle timer and commit
    if (s_q.nv_busy_flag) begin
      if (done) begin
        if (s_q.row_cycle) begin
          for (int i = 0; i < 8; i++) begin
            if (row_view.mask[i]) begin
              s_d.nv_mem[{row_view.row, 3'(i)}] =
                row_view.data[i];
            end
          end
          s_d.row_mode_enable = 1'b0;
          row_req.clear = 1'b1;
        end else begin
          s_d.nv_mem[s_q.pend_addr] = s_q.pend_data;
        end
        s_d.nv_busy_flag = 1'b0;
        s_d.row_program_start = 1'b0;
        s_d.row_cycle = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - `DBE_CNT_W'(1);
      end
    end

    // ----- Bus sequence
    case (s_q.step)
      ST_IDLE: begin
        s_d.ack = 1'b0;
        if (cyc_i && stb_i) begin
          s_d.idx = adr_i[9:2];
          s_d.wr = we_i && sel_i[0];
          s_d.wdata = dat_i[7:0];
          s_d.prog_addr = {s_q.win_page[5:0], adr_i[7:2]};
          s_d.step = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_d.ack = 1'b1;
        s_d.step = ST_ACK;
        if (!s_q.wr) begin
          // Writes leave the last read data standing
          s_d.rdata = `DBE_READ_NONE;
          if (sel_win) begin
            s_d.rdata = prog_data_i;
          end else if (sel_paged && bank_ram) begin
            s_d.rdata = s_q.ram2[off];
          end else if (sel_paged && nv_live
                       && !s_q.row_mode_enable) begin
            s_d.rdata = s_q.nv_mem[off];
          end else if (s_q.idx == `DBE_IDX_NV_CTL) begin
            // Only the busy flag reads back
            s_d.rdata = {4'h0, ctl_rd[2:1], s_q.nv_busy_flag,
              ctl_rd[0]};
          end
          // Window page and bank select read as zero
        end else begin
          if (s_q.idx == `DBE_IDX_WIN_PAGE) begin
            s_d.win_page = wd;
          end else if (s_q.idx == `DBE_IDX_BANK_SEL) begin
            s_d.bank_sel = wd;
          end else if (sel_paged && bank_ram) begin
            s_d.ram2[off] = wd;
          end else if (sel_paged && nv_live
                       && s_q.nv_write_enable) begin
            if (s_q.row_mode_enable) begin
              row_req.wr = 1'b1;
              row_req.row = off[5:3];
              row_req.idx = off[2:0];
              row_req.data = wd;
            end else begin
              // Byte mode: one byte straight into its cell
              s_d.pend_addr = off;
              s_d.pend_data = wd;
              s_d.nv_busy_flag = 1'b1;
              s_d.row_cycle = 1'b0;
              s_d.cnt = PROG_LAST;
            end
          end else if (s_q.idx == `DBE_IDX_NV_CTL
                       && !s_q.nv_busy_flag) begin
            s_d.nv_standby = wd[`DBE_CTL_STANDBY];
            s_d.nv_write_enable = wd[`DBE_CTL_WR_EN];
            s_d.row_mode_enable = wd[`DBE_CTL_ROW_MODE];
            // Arming row mode, or dropping it, empties the latches
            if (wd[`DBE_CTL_ROW_MODE] != s_q.row_mode_enable) begin
              row_req.clear = 1'b1;
            end
            if (start_row) begin
              s_d.row_program_start = 1'b1;
              s_d.nv_busy_flag = 1'b1;
              s_d.row_cycle = 1'b1;
              s_d.cnt = PROG_LAST;
            end
          end
        end
      end
      ST_ACK: begin
        s_d.ack = 1'b0;
        s_d.step = ST_IDLE;
      end
      default: begin
        s_d.ack = 1'b0;
        s_d.step = ST_IDLE;
      end
    endcase

    // ----- Synchronous reset; pages and memories keep their value
    if (rst_i) begin
      s_d.step = ST_IDLE;
      s_d.ack = 1'b0;
      s_d.rdata = 8'h00;
      s_d.idx = 8'h00;
      s_d.wr = 1'b0;
      s_d.wdata = 8'h00;
      s_d.prog_addr = 12'h000;
      s_d.win_page = s_q.win_page;
      s_d.bank_sel = s_q.bank_sel;
      s_d.nv_standby = 1'(`DBE_CTL_RESET >> `DBE_CTL_STANDBY);
      s_d.nv_write_enable = 1'b0;
      s_d.row_mode_enable = 1'b0;
      s_d.row_program_start = 1'b0;
      s_d.nv_busy_flag = 1'b0;
      s_d.row_cycle = 1'b0;
      s_d.cnt = '0;
      s_d.pend_addr = 6'h00;
      s_d.pend_data = 8'h00;
      s_d.powered = 1'b0;
      row_req = '0;
      row_req.clear = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // ==========================================================
  // Outputs
  assign dat_o = {24'h00_0000, s_q.rdata};
  assign ack_o = s_q.ack;
  assign prog_addr_o = s_q.prog_addr;
  assign nv_powered_o = s_q.powered;
  assign nv_busy_o = s_q.nv_busy_flag;

endmodule

`default_nettype wire

//--- dbe_defines.svh
// Functional notes
// - Window page low six bits steer program-memory reads; top two bits unused.
// - Window page register is write-only and not reset; software never reads it.
// - Window byte address is page bits above the six low data-address bits.
// - Bank value 10h (bit 4) maps RAM page 2 onto the paged region.
// - Bank value 01 (bit 0) maps the nonvolatile page 0 onto the region.
// - Banked accesses use addresses 00h-3Fh; 00 maps nothing, others reserved.
// - Bank select is not cleared at reset; software writes it before use.
// - Bank select is untouched by interrupts or subroutine calls.
// - Nonvolatile access is void without its bank or while in standby.
// - A programming cycle starts only with write enable set.
// - Busy flag covers each whole programming cycle; accesses then are void.
// - With standby and busy clear, a nonvolatile read is a normal read; in row mode the code returns DBE_READ_NONE instead.
// - Byte mode programs one byte; row mode up to eight in one cycle.
// - Writes go straight to the addressed location, no RAM buffer between.
// - While busy, control writes are ignored and only busy reads back.
// - A page is eight rows of eight bytes; low three bits pick the byte.
// - A STOP instruction disables the nonvolatile memory at once.
// - Row mode clears row latches, locks the row on first write.
// - Row start programs only bytes written since row mode was set.
// - Row mode clears itself when a row cycle ends.
// - Row start takes effect only with write enable and row mode set.
// - Standby disables the memory, voids accesses and cuts its power.
//
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Register index is the data-space address; byte address is 4x.
// Notes: Definitions only.
`ifndef DBE_DEFINES_SVH
`define DBE_DEFINES_SVH

// ==========================================================
// Register indexes in data space
`define DBE_IDX_WIN_PAGE 8'hC9
`define DBE_IDX_BANK_SEL 8'hE8
`define DBE_IDX_NV_CTL 8'hEA
`define DBE_PAGED_TOP 8'h3F
`define DBE_WIN_BASE 8'h40
`define DBE_WIN_TOP 8'h7F

// ==========================================================
// Bank select values
`define DBE_BANK_NONE 8'h00
`define DBE_BANK_NV0 8'h01
`define DBE_BANK_RAM2 8'h10

// ==========================================================
// Control register bits and reset value
`define DBE_CTL_STANDBY 6
`define DBE_CTL_ROW_START 3
`define DBE_CTL_ROW_MODE 2
`define DBE_CTL_BUSY 1
`define DBE_CTL_WR_EN 0
`define DBE_CTL_RESET 8'h00

// ==========================================================
// Timing
`define DBE_CLK_PERIOD_NS 40
`define DBE_PROG_TIME_NS 5000000
`define DBE_PROG_CYCLES (`DBE_PROG_TIME_NS / `DBE_CLK_PERIOD_NS)
`define DBE_CNT_W 24
`define DBE_READ_NONE 8'h00

`endif

//--- dbe_pkg.sv
// Purpose: Types shared by the paging and nonvolatile access logic.
// Assumes: Nothing beyond the defines header.
// Notes: Struct fields are packed for one-flop-per-bit state.
package dbe_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_ACK
  } dbe_step_t;

  // What the row latches show to the controller
  typedef struct packed {
    logic [7:0][7:0] data;
    logic [7:0] mask;
    logic [2:0] row;
    logic locked;
  } dbe_row_view_t;

  // Request into the row latches
  typedef struct packed {
    logic clear;
    logic wr;
    logic [2:0] row;
    logic [2:0] idx;
    logic [7:0] data;
  } dbe_row_req_t;

endpackage

//--- dbe_row_latch.sv
// Purpose: Eight volatile row latches with written-byte mask and row lock.
// Assumes: Clear and write never come in the same cycle.
// Notes: Writes to a row other than the locked one are dropped.
`timescale 1ns/1ps
`default_nettype none

module dbe_row_latch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dbe_pkg::dbe_row_req_t req_i,
  output dbe_pkg::dbe_row_view_t view_o
);
  import dbe_pkg::*;

  dbe_row_view_t s_q;
  dbe_row_view_t s_d;
  logic [7:0] hit;
  logic take;

  // A write lands only in the locked row once one is latched
  assign take = req_i.wr && (!s_q.locked || s_q.row == req_i.row);

  // ==========================================================
  // Per-byte write strobes
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_byte
      assign hit[gi] = take && (req_i.idx == 3'(gi));
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    if (req_i.clear) begin
      s_d.mask = 8'h00;
      s_d.locked = 1'b0;
    end else if (take) begin
      s_d.locked = 1'b1;
      s_d.row = req_i.row;
    end
    for (int i = 0; i < 8; i++) begin
      if (hit[i]) begin
        s_d.data[i] = req_i.data;
        s_d.mask[i] = 1'b1;
      end
    end
    if (rst_i) begin
      s_d.mask = 8'h00;
      s_d.locked = 1'b0;
      s_d.row = 3'h0;
      s_d.data = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign view_o = s_q;

endmodule

`default_nettype wire

//--- dbe_prog_mem.sv
// Purpose: Program memory seen through the read-only data window.
// Assumes: Combinational read, address held by the block.
// Notes: Content is a fold of the address so every page differs.
`timescale 1ns/1ps
`default_nettype none
module dbe_prog_mem (
  input wire logic [11:0] addr_i,
  output logic [7:0] data_o
);
  assign data_o = addr_i[7:0] ^ {addr_i[11:8], addr_i[11:8]};
endmodule
`default_nettype wire

//--- dbe_top_properties.sv
// Purpose: Bus timing and programming checks for dbe_top.
// Assumes: Sees only the top ports.
// Notes: Bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module dbe_top_checker #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [11:0] prog_addr_o,
  input wire logic [7:0] prog_data_i,
  input wire logic stop_i,
  input wire logic nv_powered_o,
  input wire logic nv_busy_o
);
  // ==========================================================
  // Busy length, too long for a repetition
  logic [23:0] busy_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !nv_busy_o) begin
      busy_cnt_q <= 24'h00_0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 24'h00_0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Assertions
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack");
  ack_delay_a: assert property (
    $rose(stb_i) |-> !ack_o ##1 !ack_o ##1 ack_o) else $error("ack delay");
  ack_cause_a: assert property (
    ack_o |-> $past(cyc_i && stb_i, 2)) else $error("ack cause");
  win_addr_a: assert property (
    $rose(stb_i) |=> prog_addr_o[5:0] == $past(adr_i[7:2]))
    else $error("win addr");
  busy_start_a: assert property (
    $rose(nv_busy_o) |-> ack_o && we_i) else $error("busy start");
  // Busy stands one cycle per count value, from the load down to zero
  busy_len_a: assert property (
    $fell(nv_busy_o) |-> busy_cnt_q == 24'(PROG_CYCLES))
    else $error("busy len");
  stop_off_a: assert property (
    stop_i |=> !nv_powered_o) else $error("stop power");
  data_hold_a: assert property (
    $changed(dat_o) |-> ack_o && !we_i) else $error("data hold");
  cover property ($rose(nv_busy_o));
  cover property (ack_o && !we_i);
  cover property ($fell(nv_powered_o));
endmodule
bind dbe_top dbe_top_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .stop_i(stop_i),
  .nv_powered_o(nv_powered_o), .nv_busy_o(nv_busy_o));
`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for paging and nonvolatile access.
// Assumes: Two-edge acknowledge, short programming count.
// Notes: Reads queue their expectation; a monitor compares on ack.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, stop_i, ack_o;
  logic nv_powered_o, nv_busy_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [11:0] prog_addr_o;
  logic [7:0] prog_data_i, q, r, k;
  logic [7:0] v[3];
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int bad_count = 0;
  int check_count = 0;
  int seed = 44105;
  dbe_top #(.PROG_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
    .stop_i(stop_i), .nv_powered_o(nv_powered_o), .nv_busy_o(nv_busy_o));
  dbe_prog_mem u_mem (.addr_i(prog_addr_o), .data_o(prog_data_i));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // ==========================================================
  // Classic single cycle, held until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic c);
    exp_q.push_back({c, x});
    wb(1'b0, a, 8'h00);
  endtask
  // Poll busy without checking each answer
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(8'hEA, 8'h00, 1'b0);
      n++;
    end while (q !== 8'h00 && n < 40);
    chk("busy end", 8'h00, q);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[8]) chk("read", e[7:0], dat_o[7:0]);
    end
  end
  initial begin
    repeat (6000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, stop_i} = 5'h10;
    adr_i = 10'h000;
    dat_i = 32'h0000_0000;
    sel_i = 4'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'hC9, 8'h00, 1'b1);
    rd(8'hE8, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      k = 8'($random(seed));
      wb(1'b1, 8'hC9, r);
      rd({2'b01, k[5:0]}, {r[1:0], k[5:0]} ^ {2{r[5:2]}}, 1'b1);
    end
    wb(1'b1, 8'hE8, 8'h10);
    wb(1'b1, 8'h05, r);
    rd(8'h05, r, 1'b1);
    wb(1'b1, 8'hE8, 8'h00);
    rd(8'h05, 8'h00, 1'b1);
    wb(1'b1, 8'hE8, 8'h01);
    wb(1'b1, 8'hEA, 8'h01);
    wb(1'b1, 8'h19, 8'h5A);
    rd(8'hEA, 8'h02, 1'b1);
    wb(1'b1, 8'hEA, 8'h40);
    rd(8'h19, 8'h00, 1'b1);
    wait_idle();
    rd(8'h19, 8'h5A, 1'b1);
    wb(1'b1, 8'hEA, 8'h00);
    wb(1'b1, 8'h19, 8'h11);
    rd(8'hEA, 8'h00, 1'b1);
    wb(1'b1, 8'hEA, 8'h09);
    rd(8'hEA, 8'h00, 1'b1);
    wb(1'b1, 8'hEA, 8'h40);
    rd(8'h19, 8'h00, 1'b1);
    chk("powered", 8'h00, {7'h00, nv_powered_o});
    wb(1'b1, 8'hEA, 8'h05);
    for (int i = 0; i < 3; i++) begin
      v[i] = 8'($random(seed));
      wb(1'b1, 8'(24 + i + (i > 0)), v[i]);
    end
    wb(1'b1, 8'h20, 8'hC3);
    wb(1'b1, 8'hEA, 8'h0D);
    rd(8'hEA, 8'h02, 1'b1);
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      rd(8'(24 + i + (i > 0)), v[i], 1'b1);
    end
    rd(8'h19, 8'h5A, 1'b1);
    wb(1'b1, 8'h19, 8'h77);
    rd(8'hEA, 8'h02, 1'b1);
    wait_idle();
    rd(8'h19, 8'h77, 1'b1);
    stop_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("powered", 8'h00, {7'h00, nv_powered_o});
    rd(8'h19, 8'h00, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
